/* File: rtl/timer_channel_pkg.sv */
package timer_channel_pkg;

  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [1:0] CTRL_ADDR    = 2'h0;
  localparam logic [1:0] COMPARE_ADDR = 2'h1;
  localparam logic [1:0] DUTY_ADDR    = 2'h2;
  localparam logic [1:0] STATUS_ADDR  = 2'h3;

  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'hFF;
  localparam logic [7:0] DUTY_RESET    = 8'hFF;

  // ****************************************************
  // control fields
  // ****************************************************
  localparam int MODE_LSB   = 0;
  localparam int MODE_MSB   = 2;
  localparam int RUN_BIT    = 3;
  localparam int SRC_LSB    = 4;
  localparam int SRC_MSB    = 6;
  localparam int FLOP_BIT   = 7;
  localparam int STAT_FLOP  = 0;
  localparam int STAT_RUN   = 1;

  localparam logic [2:0] MODE_TIMER   = 3'h0;
  localparam logic [2:0] MODE_DIVIDER = 3'h1;
  localparam logic [2:0] MODE_PWM     = 3'h2;
  localparam logic [2:0] MODE_EVENT   = 3'h3;

  localparam logic [2:0] SRC_DIV11 = 3'h0;
  localparam logic [2:0] SRC_DIV7  = 3'h1;
  localparam logic [2:0] SRC_DIV5  = 3'h2;
  localparam logic [2:0] SRC_DIV3  = 3'h3;
  localparam logic [2:0] SRC_SUB   = 3'h4;
  localparam logic [2:0] SRC_DIV1  = 3'h5;
  localparam logic [2:0] SRC_MAIN  = 3'h6;

  localparam logic [7:0] COUNT_TOP = 8'hFF;

endpackage

/* File: rtl/tick_select.sv */
`timescale 1ns/1ns
`default_nettype none
module tick_select
(
  input  wire logic       mclk,            // clock
  input  wire logic       rst,             // async reset
  input  wire logic       ce,              // clock enable
  input  wire logic [2:0] mode,            // operating mode
  input  wire logic [2:0] src,             // source select
  input  wire logic       tapSelect,       // prescaler_tap_select
  input  wire logic       slowRunMode,     // slow_run_mode or slow_idle_mode
  input  wire logic       tickDiv11,       // main / 2^11 pulse
  input  wire logic       tickDiv7,        // main / 2^7 pulse
  input  wire logic       tickDiv5,        // main / 2^5 pulse
  input  wire logic       tickDiv3,        // main / 2^3 pulse
  input  wire logic       tickSub8,        // sub / 8 pulse
  input  wire logic       tickSub,         // sub clock pulse
  input  wire logic       tickDiv1,        // main / 2 pulse
  input  wire logic       eventInputPin,   // external event level
  output logic            tick             // count enable
);

  logic eventLast;
  logic eventFall;
  logic isPwm;
  logic slowTap;
  logic intTick;

  // ****************************************************
  // source selection
  // ****************************************************
  assign isPwm     = (mode == timer_channel_pkg::MODE_PWM);
  assign slowTap   = slowRunMode | tapSelect;
  assign eventFall = eventLast & ~eventInputPin;

  always_comb
  begin
    intTick = 1'b0;
    unique case (src)
      timer_channel_pkg::SRC_DIV11: intTick = slowTap ? tickSub8 : tickDiv11;
      timer_channel_pkg::SRC_DIV7:  intTick = ~slowRunMode & tickDiv7;
      timer_channel_pkg::SRC_DIV5:  intTick = ~slowRunMode & tickDiv5;
      timer_channel_pkg::SRC_DIV3:  intTick = ~slowRunMode & tickDiv3;
      timer_channel_pkg::SRC_SUB:   intTick = isPwm & tickSub;
      timer_channel_pkg::SRC_DIV1:  intTick = isPwm & ~slowRunMode & tickDiv1;
      timer_channel_pkg::SRC_MAIN:  intTick = isPwm & ~slowRunMode;
      default:                      intTick = 1'b0;
    endcase
  end

  assign tick = (mode == timer_channel_pkg::MODE_EVENT) ? eventFall : intTick;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      eventLast <= 1'b0;
    else if (ce)
      eventLast <= eventInputPin;
  end

endmodule // tick_select
`default_nettype wire

/* File: rtl/eight_bit_timer_channel.sv */
`timescale 1ns/1ns
`default_nettype none
module eight_bit_timer_channel
(
  input  wire logic       mclk,               // clock, 10 MHz
  input  wire logic       rst,                // async reset, active high
  input  wire logic       ce,                 // clock enable
  input  wire logic [1:0] addr,               // register address
  input  wire logic [7:0] wdata,              // write data
  input  wire logic       wr,                 // write strobe
  input  wire logic       rd,                 // read strobe
  output logic      [7:0] rdata,              // read data, cycle after rd
  input  wire logic       prescalerTapSelect, // main/2^11 replaced by sub/8
  input  wire logic       slowRunMode,        // slow run or slow idle
  input  wire logic       tickDiv11,          // main / 2^11 pulse
  input  wire logic       tickDiv7,           // main / 2^7 pulse
  input  wire logic       tickDiv5,           // main / 2^5 pulse
  input  wire logic       tickDiv3,           // main / 2^3 pulse
  input  wire logic       tickSub8,           // sub / 8 pulse
  input  wire logic       tickSub,            // sub clock pulse
  input  wire logic       tickDiv1,           // main / 2 pulse
  input  wire logic       eventInputPin,      // external event input
  output logic            matchIrq,           // one-cycle interrupt pulse
  output logic            dividerOutPin,      // inverted flop
  output logic            pwmOutPin           // inverted flop
);

  logic [7:0] channelControlReg;
  logic [7:0] compareValueReg;
  logic [7:0] pwmDutyReg;
  logic [7:0] dutyActive;
  logic [7:0] count;
  logic       flop;
  logic       tick;

  logic [2:0] mode;
  logic [2:0] src;
  logic       running;
  logic       isPwm;
  logic       isMatchMode;
  logic [7:0] countInc;
  logic       cmpHit;
  logic       dutyHit;
  logic       overflow;
  logic       clearEvent;
  logic       wrCtrl;
  logic       wrCompare;
  logic       wrDuty;
  logic       flopLoad;
  logic       dutyTransfer;
  logic [7:0] next_count;
  logic       next_flop;
  logic [7:0] readMux;

  // ****************************************************
  // decode
  // ****************************************************
  assign mode        = channelControlReg[timer_channel_pkg::MODE_MSB:timer_channel_pkg::MODE_LSB];
  assign src         = channelControlReg[timer_channel_pkg::SRC_MSB:timer_channel_pkg::SRC_LSB];
  assign running     = channelControlReg[timer_channel_pkg::RUN_BIT];
  assign isPwm       = (mode == timer_channel_pkg::MODE_PWM);
  assign isMatchMode = (mode == timer_channel_pkg::MODE_TIMER) |
                       (mode == timer_channel_pkg::MODE_DIVIDER) |
                       (mode == timer_channel_pkg::MODE_EVENT);

  assign wrCtrl    = wr & (addr == timer_channel_pkg::CTRL_ADDR);
  assign wrCompare = wr & (addr == timer_channel_pkg::COMPARE_ADDR);
  assign wrDuty    = wr & (addr == timer_channel_pkg::DUTY_ADDR);

  // ****************************************************
  // counting
  // ****************************************************
  assign countInc   = count + 8'h01;
  assign cmpHit     = running & tick & isMatchMode & (countInc == compareValueReg);
  assign dutyHit    = running & tick & isPwm & (countInc == dutyActive);
  assign overflow   = running & tick & isPwm & (count == timer_channel_pkg::COUNT_TOP);
  assign clearEvent = cmpHit | overflow;

  // initial bit loads only from a control write made while already stopped
  assign flopLoad     = wrCtrl & ~running;
  assign dutyTransfer = overflow | (wrDuty & ~running);

  always_comb
  begin
    next_count = count;
    if (!running)
      next_count = 8'h00;
    else if (clearEvent)
      next_count = 8'h00;
    else if (tick & (isMatchMode | isPwm))
      next_count = countInc;
  end

  always_comb
  begin
    next_flop = flop;
    if (flopLoad)
      next_flop = wdata[timer_channel_pkg::FLOP_BIT];
    else if (cmpHit & (mode == timer_channel_pkg::MODE_DIVIDER))
      next_flop = ~flop;
    else if (dutyHit ^ overflow)
      next_flop = ~flop;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      count    <= 8'h00;
      flop     <= 1'b0;
      matchIrq <= 1'b0;
    end
    else if (ce)
    begin
      count    <= next_count;
      flop     <= next_flop;
      matchIrq <= clearEvent;
    end
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      channelControlReg <= timer_channel_pkg::CTRL_RESET;
      compareValueReg   <= timer_channel_pkg::COMPARE_RESET;
      pwmDutyReg        <= timer_channel_pkg::DUTY_RESET;
    end
    else if (ce)
    begin
      if (wrCtrl)
        channelControlReg <= wdata;
      if (wrCompare)
        compareValueReg <= wdata;
      if (wrDuty)
        pwmDutyReg <= wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      dutyActive <= timer_channel_pkg::DUTY_RESET;
    else if (ce & dutyTransfer)
      dutyActive <= (wrDuty & ~running) ? wdata : pwmDutyReg;
  end

  // ****************************************************
  // read port
  // ****************************************************
  always_comb
  begin
    readMux = 8'h00;
    unique case (addr)
      timer_channel_pkg::CTRL_ADDR:    readMux = channelControlReg;
      timer_channel_pkg::COMPARE_ADDR: readMux = compareValueReg;
      timer_channel_pkg::DUTY_ADDR:    readMux = (isPwm & running) ? dutyActive : pwmDutyReg;
      timer_channel_pkg::STATUS_ADDR:  readMux = count;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (ce & rd)
      rdata <= readMux;
  end

  // ****************************************************
  // pins
  // ****************************************************
  assign dividerOutPin = ~flop;
  assign pwmOutPin     = ~flop;

  tick_select ticks
  (
    .mclk          (mclk),
    .rst           (rst),
    .ce            (ce),
    .mode          (mode),
    .src           (src),
    .tapSelect     (prescalerTapSelect),
    .slowRunMode   (slowRunMode),
    .tickDiv11     (tickDiv11),
    .tickDiv7      (tickDiv7),
    .tickDiv5      (tickDiv5),
    .tickDiv3      (tickDiv3),
    .tickSub8      (tickSub8),
    .tickSub       (tickSub),
    .tickDiv1      (tickDiv1),
    .eventInputPin (eventInputPin),
    .tick          (tick)
  );

endmodule // eight_bit_timer_channel
`default_nettype wire

/* File: dv/timer_channel_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module timer_channel_asserts
(
  input wire logic       mclk,          // clock
  input wire logic       rst,           // reset
  input wire logic       ce,            // enable
  input wire logic [1:0] addr,          // address
  input wire logic [7:0] wdata,         // write data
  input wire logic       wr,            // write strobe
  input wire logic       rd,            // read strobe
  input wire logic [7:0] rdata,         // read data
  input wire logic       matchIrq,      // interrupt
  input wire logic       dividerOutPin, // divider pin
  input wire logic       pwmOutPin      // pwm pin
);
  // ********
  // control shadow
  // ********
  logic [7:0] ctrl;
  wire        ctlWr = ce && wr && addr == timer_channel_pkg::CTRL_ADDR;
  wire        run   = ctrl[timer_channel_pkg::RUN_BIT];
  wire        quiet = ctrl[2:0] inside {timer_channel_pkg::MODE_TIMER, timer_channel_pkg::MODE_EVENT};
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      ctrl <= timer_channel_pkg::CTRL_RESET;
    else if (ctlWr)
      ctrl <= wdata;
  // ********
  // properties
  // ********
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_irq_one_cycle: assert property (matchIrq |=> !matchIrq) else $error("irq too long");
  a_stop_no_irq: assert property (!run [*2] |=> !matchIrq) else $error("irq stopped");
  a_pins_agree: assert property (dividerOutPin == pwmOutPin) else $error("pins differ");
  a_stop_holds: assert property (!run && !ctlWr |=> $stable(dividerOutPin)) else $error("pin moved");
  a_flop_load: assert property
    (ctlWr && !run |=> dividerOutPin == !$past(wdata[timer_channel_pkg::FLOP_BIT])) else $error("flop load");
  a_timer_quiet: assert property (run && quiet && !ctlWr |=> $stable(pwmOutPin)) else $error("toggled");
  a_release_idle: assert property ($past(rst) |-> dividerOutPin && !matchIrq) else $error("reset");
  a_rdata_stands: assert property (!(ce && rd) |=> $stable(rdata)) else $error("rdata moved");
  c_pwm_irq: cover property (matchIrq && ctrl[2:0] == timer_channel_pkg::MODE_PWM);
  c_flop_load: cover property (ctlWr && !run);
  c_toggle: cover property (run && $changed(dividerOutPin));
endmodule // timer_channel_asserts
bind eight_bit_timer_channel timer_channel_asserts chk_u
(
  .mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .matchIrq(matchIrq), .dividerOutPin(dividerOutPin), .pwmOutPin(pwmOutPin)
);
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic       mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tap = 1'b0, slow = 1'b0, ev = 1'b1, ce = 1'b1;
  logic       irq, dPin, pPin, hold;
  logic [1:0] addr = 2'h0;
  logic [6:0] tk = 7'h00;
  logic [7:0] wdata = 8'h00, rdata, v;
  int         n, lo, cyc = 0, error_cnt = 0, cmp_count = 0;
  eight_bit_timer_channel dut_u
  (
    .mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .prescalerTapSelect(tap), .slowRunMode(slow), .tickDiv11(tk[0]), .tickDiv7(tk[1]), .tickDiv5(tk[2]),
    .tickDiv3(tk[3]), .tickSub8(tk[4]), .tickSub(tk[5]), .tickDiv1(tk[6]), .eventInputPin(ev),
    .matchIrq(irq), .dividerOutPin(dPin), .pwmOutPin(pPin)
  );
  initial forever #50 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      $display("MISMATCH %0t timeout", $time);
      tally_and_finish();
    end
  end
  // ********
  // bus and checks
  // ********
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %0d exp %0d", $time, g, e);
    end
  endtask
  task automatic wrReg(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic wrCtl(input logic [7:0] d);
    wrReg(timer_channel_pkg::CTRL_ADDR, d);
  endtask
  task automatic rdReg(input logic [1:0] a);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    v = rdata;
  endtask
  // counts cycles up to the next interrupt and the pwm pin's low cycles
  task automatic waitIrq();
    n  = 0;
    lo = 0;
    do
    begin
      @(negedge mclk);
      n++;
      lo += (pPin === 1'b0);
    end
    while (irq !== 1'b1 && n < 2000);
    if (irq !== 1'b1)
    begin
      error_cnt++;
      $display("MISMATCH %0t no interrupt", $time);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ********
  // scenarios
  // ********
  task automatic tSources();
    logic [7:0] ctl [8] = '{8'h08, 8'h08, 8'h08, 8'h18, 8'h28, 8'h38, 8'h4A, 8'h5A};
    int         idx [8] = '{0, 4, 4, 1, 2, 3, 5, 6};
    rdReg(timer_channel_pkg::DUTY_ADDR);
    chk({1'b0, v}, {1'b0, timer_channel_pkg::DUTY_RESET});
    for (int i = 0; i < 8; i++)
    begin
      wrCtl(8'h00);
      tap  <= i == 1;
      slow <= i == 2;
      wrCtl(ctl[i]);
      tk <= ~(7'h01 << idx[i]);
      repeat (4) @(posedge mclk);
      tk <= 7'h01 << idx[i];
      repeat (3) @(posedge mclk);
      tk <= 7'h00;
      rdReg(timer_channel_pkg::STATUS_ADDR);
      chk({1'b0, v}, 9'h003);
    end
  endtask
  task automatic tTimer();
    tap  <= 1'b0;
    slow <= 1'b0;
    wrCtl(8'h00);
    wrReg(timer_channel_pkg::COMPARE_ADDR, 8'h03);
    wrCtl(8'h10);
    tk <= 7'h02;
    wrCtl(8'h18);
    waitIrq();
    waitIrq();
    chk(n[8:0], 9'h003);
    wrReg(timer_channel_pkg::COMPARE_ADDR, 8'h05);
    waitIrq();
    waitIrq();
    chk(n[8:0], 9'h005);
  endtask
  task automatic tDivider();
    wrCtl(8'h11);
    wrCtl(8'h19);
    waitIrq();
    hold = dPin;
    waitIrq();
    chk({8'h00, dPin}, {8'h00, ~hold});
    wrCtl(8'h91);
    repeat (6) @(negedge mclk);
    chk({8'h00, dPin}, {8'h00, ~hold});
    wrCtl(8'h91);
    @(negedge mclk);
    chk({8'h00, dPin}, 9'h000);
    wrCtl(8'h11);
    @(negedge mclk);
    chk({8'h00, dPin}, 9'h001);
  endtask
  task automatic tEvent();
    wrReg(timer_channel_pkg::COMPARE_ADDR, 8'h03);
    wrCtl(8'h0B);
    repeat (2)
    begin
      ev <= 1'b0;
      repeat (2) @(posedge mclk);
      ev <= 1'b1;
      repeat (2) @(posedge mclk);
    end
    rdReg(timer_channel_pkg::STATUS_ADDR);
    chk({1'b0, v}, 9'h002);
    @(posedge mclk);
    ev <= 1'b0;
    waitIrq();
    chk({8'h00, irq}, 9'h001);
    chk(n[8:0], 9'h002);
    @(posedge mclk);
    ev <= 1'b1;
  endtask
  task automatic tPwm();
    wrCtl(8'h62);
    wrReg(timer_channel_pkg::DUTY_ADDR, 8'h40);
    wrCtl(8'h6A);
    waitIrq();
    waitIrq();
    chk(n[8:0], 9'h100);
    chk(lo[8:0], 9'h0C0);
    wrReg(timer_channel_pkg::DUTY_ADDR, 8'h20);
    rdReg(timer_channel_pkg::DUTY_ADDR);
    chk({1'b0, v}, 9'h040);
    waitIrq();
    waitIrq();
    chk(lo[8:0], 9'h0E0);
    rdReg(timer_channel_pkg::DUTY_ADDR);
    chk({1'b0, v}, 9'h020);
    wrCtl(8'h62);
    wrCtl(8'hEA);
    waitIrq();
    waitIrq();
    chk(lo[8:0], 9'h020);
    wrCtl(8'h62);
  endtask
  // clock enable low must freeze the count
  task automatic tFreeze();
    wrCtl(8'h10);
    wrCtl(8'h18);
    @(posedge mclk);
    ce <= 1'b0;
    repeat (10) @(posedge mclk);
    ce <= 1'b1;
    rdReg(timer_channel_pkg::STATUS_ADDR);
    chk({1'b0, v}, 9'h002);
  endtask
  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    tSources();
    tTimer();
    tFreeze();
    tDivider();
    tEvent();
    tPwm();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
